// File: bfce_host.sv
/*
  Host-side controller for a light-control display controller: issues
  batch, flash program/read and illumination-bin commands over the serial
  command link and polls the device status byte.
  Assumes a software master on the plain register port and a frame-sync
  pin from the video path; link and sync pins are asynchronous.
*/
// Function
// - Host sends no further command while a group runs and pending is set
// - Program only in boot or main standby; reading only in main
// - Main update order: select, erase, write data, then verify
// - Each write at most 256 bytes, multiple of 4, poll after each
// - After erase or verify poll until tag matches and pending clear
// - Each read at most 256 bytes, zero-based length field, multiple of 4
// - Query stored size first, read until total equals it, then stop
// - Boot writes send full 256-byte pages padded with 0xFF
// - For quad read resend interface rate after writes, before verify; verify checks this in boot mode only
// - Bin write starts 4 ms after sync edge, ends 1 ms before next
`timescale 1ns/1ps
`include "bfce_regs.svh"
module bfce_host #(
  parameter int unsigned SYNC_OPEN_CYC =
    `BFCE_T_SYNC_OPEN_MS * `BFCE_US_PER_MS * `BFCE_CLK_MHZ,
  parameter int unsigned SYNC_CLOSE_CYC =
    `BFCE_T_SYNC_CLOSE_MS * `BFCE_US_PER_MS * `BFCE_CLK_MHZ,
  parameter int unsigned XFER_CYC = 200,
  parameter logic [7:0] GAP_CYC = 8'h08,
  parameter logic [7:0] LINK_DIV = 8'h04
) (
  input logic i_clock,
  input logic i_rst_n,
  input logic [7:0] i_addr,
  input logic [31:0] i_wdata,
  input logic i_wr,
  input logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_busy,
  output logic o_link_sclk,
  output logic o_link_cs_n,
  output logic o_link_mosi,
  input logic i_link_miso,
  input logic i_frame_sync
);
  bfce_pkg::bfce_state_t s;
  bfce_pkg::bfce_state_t n;
  bfce_pkg::bfce_phase_t f_ph;
  logic [7:0] mem [256];
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] spi_rx;
  logic spi_done;
  logic [7:0] tx_b;
  logic [7:0] f_op;
  logic [3:0] code;
  logic [16:0] rd_sum;
  logic [8:0] pay_idx;
  logic boot, standby, quad, len_ok, cmd_go, ok, refuse, err_set;
  logic clr_ref, clr_err, vs_edge, bin_go, pend, tag_ok;
  logic f_rd, f_cap, f_data, f_bin;

  bfce_spi_byte #(
    .DIV(LINK_DIV)
  ) u_spi (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_start(s.start),
    .i_tx(s.tx),
    .i_miso(s.miso[1]),
    .o_sclk(o_link_sclk),
    .o_mosi(o_link_mosi),
    .o_rx(spi_rx),
    .o_done(spi_done)
  );

  always_comb begin
    n = s;
    n.start = 1'b0;
    n.rdata = 32'h0;
    mem_we = 1'b0;
    mem_wa = s.ptr;
    mem_wd = i_wdata[7:0];
    ok = 1'b0;
    err_set = 1'b0;
    f_op = 8'h00;
    f_ph = s.phase;
    f_rd = 1'b0;
    f_cap = 1'b0;
    f_data = 1'b0;
    f_bin = 1'b0;
    code = i_wdata[3:0];
    boot = s.cfg[`BFCE_CFG_BOOT];
    standby = s.cfg[`BFCE_CFG_STANDBY];
    quad = s.cfg[`BFCE_CFG_QUAD];
    len_ok = s.len != 9'h000 && s.len <= `BFCE_MAX_LEN && s.len[1:0] == 2'h0;
    rd_sum = s.rd_cnt + {8'h00, s.len};
    cmd_go = i_wr && i_addr == `BFCE_A_CMD;
    clr_ref = i_wr && i_addr == `BFCE_A_STAT && i_wdata[`BFCE_STAT_CLR_REF];
    clr_err = i_wr && i_addr == `BFCE_A_STAT && i_wdata[`BFCE_STAT_CLR_ERR];
    pend = s.stat[`BFCE_ST_PEND_BIT];
    tag_ok = s.stat[`BFCE_ST_TAG_MSB:`BFCE_ST_TAG_LSB] == s.tag;
    pay_idx = s.idx - `BFCE_HDR_BYTES;
    // Frame sync and data-in synchronisers
    n.vs = {s.vs[1:0], i_frame_sync};
    n.miso = {s.miso[0], i_link_miso};
    vs_edge = s.vs[1] && !s.vs[2];
    if (vs_edge) begin
      n.frame_per = s.since_vs;
      n.since_vs = 24'h0;
    end else if (s.since_vs != `BFCE_CNT_MAX) begin
      n.since_vs = s.since_vs + 24'h1;
    end
    // Unknown frame period: send anyway, device still applies it
    bin_go = 32'(s.since_vs) >= SYNC_OPEN_CYC && (s.frame_per == 24'h0 ||
      32'(s.since_vs) + SYNC_CLOSE_CYC + XFER_CYC <= 32'(s.frame_per));
    // Byte to send at the current frame position
    if (s.idx == 9'h000) begin
      tx_b = s.op;
    end else if (s.idx == 9'h001) begin
      tx_b = s.arg;
    end else if (s.idx == 9'h002) begin
      tx_b = s.lenm1;
    end else if (s.is_read) begin
      tx_b = `BFCE_DUMMY_BYTE;
    end else if (pay_idx >= s.dlen) begin
      tx_b = `BFCE_PAD_BYTE;
    end else begin
      tx_b = mem[pay_idx[7:0]];
    end
    // Software register port
    if (i_rd) begin
      case (i_addr)
        `BFCE_A_CFG: n.rdata = {29'h0, s.cfg};
        `BFCE_A_LEN: n.rdata = {23'h0, s.len};
        `BFCE_A_STAT: n.rdata = {16'h0, s.stat, 2'h0, s.rate_after, s.phase,
          s.dev_err, s.refused, s.busy};
        `BFCE_A_BPTR: n.rdata = {24'h0, s.ptr};
        `BFCE_A_BDAT: begin
          n.rdata = {24'h0, mem[s.ptr]};
          n.ptr = s.ptr + 8'h01;
        end
        `BFCE_A_SIZE: n.rdata = s.size;
        `BFCE_A_RCNT: n.rdata = {15'h0, s.rd_cnt};
        default: n.rdata = 32'h0;
      endcase
    end
    if (i_wr) begin
      case (i_addr)
        `BFCE_A_CFG: n.cfg = i_wdata[2:0];
        `BFCE_A_LEN: n.len = i_wdata[8:0];
        `BFCE_A_BPTR: n.ptr = i_wdata[7:0];
        `BFCE_A_BDAT: begin
          mem_we = 1'b1;
          n.ptr = s.ptr + 8'h01;
        end
        default: ;
      endcase
    end
    // Link sequencing
    unique case (s.st)
      bfce_pkg::ST_IDLE: ;
      bfce_pkg::ST_WAITBIN: begin
        if (bin_go) begin
          n.st = bfce_pkg::ST_XFER;
          n.cs_n = 1'b0;
        end
      end
      bfce_pkg::ST_XFER: begin
        if (!s.wait_b) begin
          n.start = 1'b1;
          n.tx = tx_b;
          n.wait_b = 1'b1;
        end else if (spi_done) begin
          n.wait_b = 1'b0;
          n.idx = s.idx + 9'h001;
          if (s.poll && s.idx == 9'h001) begin
            n.stat = spi_rx;
          end
          if (s.is_read && s.idx >= `BFCE_HDR_BYTES) begin
            mem_we = 1'b1;
            mem_wa = pay_idx[7:0];
            mem_wd = spi_rx;
            if (s.cap) begin
              n.size = {s.size[23:0], spi_rx};
            end
          end
          if (s.idx + 9'h001 == s.nbytes) begin
            n.cs_n = 1'b1;
            n.st = bfce_pkg::ST_GAP;
            n.gap = GAP_CYC;
          end
        end
      end
      bfce_pkg::ST_GAP: begin
        if (s.gap != 8'h00) begin
          n.gap = s.gap - 8'h01;
        end else if ((s.poll && (pend || !tag_ok)) || (!s.poll && !s.is_read)) begin
          n.op = `BFCE_OP_STATUS;
          n.arg = 8'h00;
          n.nbytes = `BFCE_CMD_BYTES;
          n.idx = 9'h000;
          n.poll = 1'b1;
          n.cs_n = 1'b0;
          n.st = bfce_pkg::ST_XFER;
        end else begin
          n.st = bfce_pkg::ST_IDLE;
          n.busy = 1'b0;
          err_set = s.poll && s.stat[`BFCE_ST_ERR_BIT];
        end
      end
    endcase
    // Command acceptance
    if (cmd_go && !s.busy) begin
      case (code)
        `BFCE_CMD_BATCH: begin
          ok = !boot;
          f_op = `BFCE_OP_BATCH;
        end
        `BFCE_CMD_SELECT: begin
          ok = !boot && standby;
          f_op = `BFCE_OP_SELECT;
          f_ph = bfce_pkg::PH_SEL;
        end
        `BFCE_CMD_ERASE: begin
          ok = boot || (standby && s.phase == bfce_pkg::PH_SEL);
          f_op = boot ? `BFCE_OP_FULL_ERASE : `BFCE_OP_ERASE;
          f_ph = bfce_pkg::PH_ERA;
        end
        `BFCE_CMD_WRITE: begin
          ok = len_ok && (boot || standby) &&
            (s.phase == bfce_pkg::PH_ERA || s.phase == bfce_pkg::PH_WR);
          f_op = `BFCE_OP_WRITE;
          f_ph = bfce_pkg::PH_WR;
          f_data = 1'b1;
        end
        `BFCE_CMD_VERIFY: begin
          ok = s.phase == bfce_pkg::PH_WR && !(boot && quad && !s.rate_after);
          f_op = `BFCE_OP_VERIFY;
          f_ph = bfce_pkg::PH_NONE;
        end
        `BFCE_CMD_RATE: begin
          ok = 1'b1;
          f_op = `BFCE_OP_RATE;
        end
        `BFCE_CMD_SIZE: begin
          ok = !boot;
          f_op = `BFCE_OP_SIZE;
          f_rd = 1'b1;
          f_cap = 1'b1;
        end
        `BFCE_CMD_READ: begin
          ok = !boot && len_ok && s.size != 32'h0 && {15'h0, rd_sum} <= s.size;
          f_op = `BFCE_OP_READ;
          f_rd = 1'b1;
          f_data = 1'b1;
        end
        `BFCE_CMD_BIN: begin
          ok = !boot;
          f_op = `BFCE_OP_BIN;
          f_bin = 1'b1;
        end
        default: ok = 1'b0;
      endcase
    end
    refuse = cmd_go && !ok;
    if (ok) begin
      n.busy = 1'b1;
      n.op = f_op;
      n.arg = i_wdata[15:8];
      n.tag = f_op[3:0];
      n.idx = 9'h000;
      n.wait_b = 1'b0;
      n.poll = 1'b0;
      n.is_read = f_rd;
      n.cap = f_cap;
      n.phase = f_ph;
      n.dlen = s.len;
      n.nbytes = `BFCE_CMD_BYTES;
      n.lenm1 = 8'h00;
      if (f_data && boot) begin
        n.nbytes = `BFCE_HDR_BYTES + `BFCE_MAX_LEN;
        n.lenm1 = 8'(`BFCE_MAX_LEN - 9'h001);
      end else if (f_data) begin
        n.nbytes = `BFCE_HDR_BYTES + s.len;
        n.lenm1 = 8'(s.len - 9'h001);
      end
      if (f_cap) begin
        n.nbytes = `BFCE_HDR_BYTES + `BFCE_SIZE_BYTES;
        n.lenm1 = 8'(`BFCE_SIZE_BYTES - 9'h001);
        n.size = 32'h0;
        n.rd_cnt = 17'h0;
      end
      if (code == `BFCE_CMD_READ) begin
        n.rd_cnt = rd_sum;
      end
      if (code == `BFCE_CMD_WRITE) begin
        n.rate_after = 1'b0;
      end else if (code == `BFCE_CMD_RATE && s.phase == bfce_pkg::PH_WR) begin
        n.rate_after = 1'b1;
      end
      n.st = f_bin ? bfce_pkg::ST_WAITBIN : bfce_pkg::ST_XFER;
      n.cs_n = f_bin;
    end
    // Set wins over a same-cycle clear
    n.refused = (s.refused && !clr_ref) || refuse;
    n.dev_err = (s.dev_err && !clr_err) || err_set;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.st <= bfce_pkg::ST_IDLE;
      s.cs_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge i_clock) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign o_rdata = s.rdata;
  assign o_busy = s.busy;
  assign o_link_cs_n = s.cs_n;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence cmd_wr;
    i_wr && i_addr == `BFCE_A_CMD;
  endsequence
  sequence cmd_frame_end;
    $rose(o_link_cs_n) && !s.poll && !s.is_read;
  endsequence
  sequence poll_frame_start;
    $fell(o_link_cs_n) && s.poll;
  endsequence

  a_busy_refuse: assert property (cmd_wr ##0 s.busy |=> s.refused)
    else $error("command taken while busy");
  a_boot_batch: assert property (cmd_wr ##0 (code == `BFCE_CMD_BATCH && boot && !s.busy)
    |=> s.refused && !s.busy) else $error("batch started in boot");
  a_boot_select: assert property (cmd_wr ##0 (code == `BFCE_CMD_SELECT && boot)
    |=> s.refused && o_link_cs_n[*2]) else $error("block select in boot");
  a_write_len: assert property (cmd_wr ##0 (code == `BFCE_CMD_WRITE && s.len[1:0] != 2'h0)
    |=> s.refused) else $error("odd write length taken");
  a_erase_order: assert property (cmd_wr ##0 (code == `BFCE_CMD_ERASE && !boot && !s.busy
    && s.phase != bfce_pkg::PH_SEL) |=> s.refused) else $error("erase before select");
  a_verify_rate: assert property (cmd_wr ##0 (code == `BFCE_CMD_VERIFY && boot && quad
    && !s.rate_after) |=> s.refused) else $error("verify without rate resend");
  a_poll_follows: assert property (cmd_frame_end |-> s.busy ##[1:40] poll_frame_start)
    else $error("no status poll after command");
  a_err_capture: assert property (s.st == bfce_pkg::ST_GAP && s.gap == 8'h00 && s.poll
    && !pend && tag_ok && s.stat[`BFCE_ST_ERR_BIT] |=> s.dev_err && !s.busy)
    else $error("device error not captured");
  a_bin_window: assert property ($fell(o_link_cs_n) && s.op == `BFCE_OP_BIN
    |-> $past(s.since_vs) >= 24'(SYNC_OPEN_CYC - 1)) else $error("bin sent early");
  a_read_field: assert property ($fell(o_link_cs_n) && s.is_read && !s.cap && !boot
    |-> s.lenm1 == 8'(s.dlen - 9'h001)) else $error("read length not zero-based");
  a_read_limit: assert property (s.size != 32'h0 && !s.cap |-> {15'h0, s.rd_cnt} <= s.size)
    else $error("read past stored size");
endmodule

// File: bfce_regs.svh
/*
  Named constants of the batch and flash command engine host controller:
  software register map, field positions, command codes, link opcodes,
  status-byte layout and timing figures.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef BFCE_REGS_SVH
`define BFCE_REGS_SVH

// Software register byte addresses
`define BFCE_A_CMD 8'h00
`define BFCE_A_CFG 8'h04
`define BFCE_A_LEN 8'h08
`define BFCE_A_STAT 8'h0c
`define BFCE_A_BPTR 8'h10
`define BFCE_A_BDAT 8'h14
`define BFCE_A_SIZE 8'h18
`define BFCE_A_RCNT 8'h1c

// Configuration bits
`define BFCE_CFG_BOOT 0
`define BFCE_CFG_STANDBY 1
`define BFCE_CFG_QUAD 2

// Status register write-one-to-clear bits
`define BFCE_STAT_CLR_REF 1
`define BFCE_STAT_CLR_ERR 2

// Software command codes, CMD[3:0]
`define BFCE_CMD_BATCH 4'h0
`define BFCE_CMD_SELECT 4'h1
`define BFCE_CMD_ERASE 4'h2
`define BFCE_CMD_WRITE 4'h3
`define BFCE_CMD_VERIFY 4'h4
`define BFCE_CMD_RATE 4'h5
`define BFCE_CMD_SIZE 4'h6
`define BFCE_CMD_READ 4'h7
`define BFCE_CMD_BIN 4'h8

// Link opcodes
`define BFCE_OP_BATCH 8'h21
`define BFCE_OP_SELECT 8'ha0
`define BFCE_OP_ERASE 8'ha1
`define BFCE_OP_WRITE 8'ha2
`define BFCE_OP_VERIFY 8'ha4
`define BFCE_OP_FULL_ERASE 8'ha9
`define BFCE_OP_RATE 8'haa
`define BFCE_OP_SIZE 8'ha5
`define BFCE_OP_READ 8'ha6
`define BFCE_OP_BIN 8'h3a
`define BFCE_OP_STATUS 8'h5f

// Device status byte layout
`define BFCE_ST_PEND_BIT 0
`define BFCE_ST_ERR_BIT 1
`define BFCE_ST_TAG_MSB 7
`define BFCE_ST_TAG_LSB 4

// Frame layout
`define BFCE_HDR_BYTES 9'h003
`define BFCE_CMD_BYTES 9'h002
`define BFCE_SIZE_BYTES 9'h004
`define BFCE_MAX_LEN 9'h100
`define BFCE_PAD_BYTE 8'hff
`define BFCE_DUMMY_BYTE 8'h00
`define BFCE_CNT_MAX 24'hffffff

// Timing
`define BFCE_CLK_MHZ 100
`define BFCE_US_PER_MS 1000
`define BFCE_T_SYNC_OPEN_MS 4
`define BFCE_T_SYNC_CLOSE_MS 1

`endif

// File: bfce_pkg.sv
/*
  Types of the batch and flash command engine host controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bfce_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAITBIN = 4'h2,
    ST_XFER = 4'h4,
    ST_GAP = 4'h8
  } bfce_st_t;

  typedef enum logic [1:0] {
    PH_NONE = 2'h0,
    PH_SEL = 2'h1,
    PH_ERA = 2'h2,
    PH_WR = 2'h3
  } bfce_phase_t;

  typedef struct packed {
    bfce_st_t st;
    logic cs_n;
    logic start;
    logic [7:0] tx;
    logic wait_b;
    logic [8:0] idx;
    logic [8:0] nbytes;
    logic [7:0] op;
    logic [7:0] arg;
    logic [7:0] lenm1;
    logic [8:0] dlen;
    logic [3:0] tag;
    logic poll;
    logic is_read;
    logic cap;
    logic busy;
    logic refused;
    logic dev_err;
    logic [7:0] stat;
    bfce_phase_t phase;
    logic rate_after;
    logic [2:0] cfg;
    logic [8:0] len;
    logic [7:0] ptr;
    logic [31:0] size;
    logic [16:0] rd_cnt;
    logic [7:0] gap;
    logic [2:0] vs;
    logic [1:0] miso;
    logic [23:0] since_vs;
    logic [23:0] frame_per;
    logic [31:0] rdata;
  } bfce_state_t;

  typedef struct packed {
    logic active;
    logic sclk;
    logic mosi;
    logic [2:0] bit_n;
    logic [7:0] cnt;
    logic [7:0] sh;
    logic [7:0] rx;
    logic done;
  } bfce_spi_t;
endpackage

// File: bfce_spi_byte.sv
/*
  One-byte serial shifter for the command link, mode 0, MSB first.
  Assumes i_miso is already synchronised and i_start is a one-cycle pulse
  given only while idle.
*/
`timescale 1ns/1ps
module bfce_spi_byte #(
  parameter logic [7:0] DIV = 8'h04
) (
  input logic i_clock,
  input logic i_rst_n,
  input logic i_start,
  input logic [7:0] i_tx,
  input logic i_miso,
  output logic o_sclk,
  output logic o_mosi,
  output logic [7:0] o_rx,
  output logic o_done
);
  bfce_pkg::bfce_spi_t s;
  bfce_pkg::bfce_spi_t n;
  logic tick;

  always_comb begin
    n = s;
    n.done = 1'b0;
    tick = s.cnt == DIV - 8'h01;
    if (!s.active) begin
      n.cnt = 8'h00;
      if (i_start) begin
        n.active = 1'b1;
        n.sh = i_tx;
        n.mosi = i_tx[7];
        n.bit_n = 3'h0;
      end
    end else if (!tick) begin
      n.cnt = s.cnt + 8'h01;
    end else begin
      n.cnt = 8'h00;
      n.sclk = !s.sclk;
      if (!s.sclk) begin
        n.rx = {s.rx[6:0], i_miso};
      end else if (s.bit_n == 3'h7) begin
        n.active = 1'b0;
        n.done = 1'b1;
      end else begin
        n.bit_n = s.bit_n + 3'h1;
        n.sh = {s.sh[6:0], 1'b0};
        n.mosi = s.sh[6];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_sclk = s.sclk;
  assign o_mosi = s.mosi;
  assign o_rx = s.rx;
  assign o_done = s.done;
endmodule

// File: bfce_dev_model.sv
/*
  Behavioural device on the command link: takes frames and answers status
  polls, size queries and reads.
  Assumes mode 0 frames, MSB first, from the host controller.
*/
`timescale 1ns/1ps
module bfce_dev_model (
  input logic i_sclk,
  input logic i_cs_n,
  input logic i_mosi,
  output logic o_miso
);
  logic [7:0] sh = 8'h00, op = 8'h00, arg, lenm1, cop = 8'h00, otag = 8'h00;
  logic [7:0] carg, clen, t;
  logic [7:0] pay [256];
  logic err = 1'b0, bad = 1'b0, o = 1'b0;
  logic [31:0] size = 32'h0;
  int bc = 0, npay = 0, cnp = 0, pend = 0, slow = 0, frames = 0, polls = 0;
  function automatic logic [7:0] txb(int i);
    if (op == 8'h5f && i == 1)
      return {pend != 0 ? otag[3:0] : cop[3:0], 2'h0, err, pend != 0};
    if (op == 8'ha5 && i >= 3)
      return size[8*(6-i) +: 8];
    if (op == 8'ha6 && i >= 3)
      return 8'(i + 64);
    return 8'h00;
  endfunction
  always @(negedge i_cs_n) begin
    bc = 0;
    npay = 0;
    o = 1'b0;
  end
  always @(posedge i_sclk) if (!i_cs_n) begin
    sh = {sh[6:0], i_mosi};
    bc++;
    if (bc == 8) op = sh;
    else if (bc == 16) arg = sh;
    else if (bc == 24) lenm1 = sh;
    else if (bc % 8 == 0) begin
      pay[8'(bc / 8 - 4)] = sh;
      npay++;
    end
  end
  always @(negedge i_sclk) if (!i_cs_n) begin
    t = txb(bc / 8);
    o = t[7 - bc % 8];
  end
  // Tag and pending change together when the last busy poll is over
  always @(posedge i_cs_n) if (bc >= 16) begin
    if (op == 8'h5f) begin
      polls++;
      if (pend > 0) pend--;
    end else begin
      frames++;
      otag = cop;
      cop = op;
      carg = arg;
      clen = lenm1;
      cnp = npay;
      pend = slow;
      err = op == 8'ha4 && bad;
    end
  end
  // Released line shows the inverse of the last bit
  assign o_miso = i_cs_n ? ~o : o;
endmodule

// File: bfce_tb.sv
/*
  Self-checking bench of the host controller with a behavioural device on
  the link and a free-running frame sync.
  Assumes bfce_host as the block under test.
*/
`timescale 1ns/1ps
`include "bfce_regs.svh"
module testbench;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_frame_sync = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, got;
  logic o_busy, o_link_sclk, o_link_cs_n, o_link_mosi, i_link_miso;
  int err_count = 0, n_tests = 0, since = 0;
  bfce_host #(.SYNC_OPEN_CYC(400), .SYNC_CLOSE_CYC(100)) dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy),
    .o_link_sclk(o_link_sclk), .o_link_cs_n(o_link_cs_n), .o_link_mosi(o_link_mosi),
    .i_link_miso(i_link_miso), .i_frame_sync(i_frame_sync)
  );
  bfce_dev_model dev (.i_sclk(o_link_sclk), .i_cs_n(o_link_cs_n), .i_mosi(o_link_mosi),
    .o_miso(i_link_miso));
  initial forever #5 i_clock = ~i_clock;
  // Frame period of 2000 cycles
  always @(posedge i_clock) begin
    since <= (since == 1999) ? 0 : since + 1;
    i_frame_sync <= since < 1000;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [7:0] a);
    wr(`BFCE_A_CMD, {16'h0, a, 4'h0, c});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge i_clock);
    #1;
    while (o_busy !== 1'b0 && n < 40000) begin
      @(posedge i_clock);
      #1 n++;
    end
    chk({31'h0, o_busy}, 32'h0);
  endtask
  task automatic run(input logic [3:0] c, input logic [7:0] a);
    cmd(c, a);
    wait_idle;
  endtask
  task automatic refuse(input logic [3:0] c, input logic [7:0] a);
    cmd(c, a);
    rd(`BFCE_A_STAT);
    chk({31'h0, got[1]}, 32'h1);
    wr(`BFCE_A_STAT, 32'h2);
  endtask
  task automatic fill(input int n, input logic [7:0] b);
    wr(`BFCE_A_BPTR, 32'h0);
    for (int i = 0; i < n; i++) wr(`BFCE_A_BDAT, {24'h0, b + 8'(i)});
  endtask
  task automatic t_reset;
    logic [7:0] ra [6] = '{`BFCE_A_CFG, `BFCE_A_LEN, `BFCE_A_STAT, `BFCE_A_SIZE,
      `BFCE_A_RCNT, 8'h40};
    chk({30'h0, o_link_cs_n, o_link_sclk}, 32'h2);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(got, 32'h0);
    end
  endtask
  task automatic t_batch;
    int f, p;
    wr(`BFCE_A_CFG, 32'h2);
    dev.slow = 3;
    f = dev.frames;
    p = dev.polls;
    cmd(`BFCE_CMD_BATCH, 8'h03);
    refuse(`BFCE_CMD_SIZE, 8'h00);
    wait_idle;
    chk(dev.frames - f, 1);
    chk(dev.polls - p, 4);
    chk({dev.cop, dev.carg}, 32'h2103);
    rd(`BFCE_A_STAT);
    chk(got, 32'h1000);
  endtask
  task automatic t_prog;
    dev.slow = 1;
    wr(`BFCE_A_LEN, 32'h8);
    refuse(`BFCE_CMD_WRITE, 8'h00);
    refuse(`BFCE_CMD_ERASE, 8'h00);
    run(`BFCE_CMD_SELECT, 8'h05);
    chk(dev.cop, 32'ha0);
    run(`BFCE_CMD_ERASE, 8'h00);
    chk(dev.cop, 32'ha1);
    wr(`BFCE_A_LEN, 32'h6);
    refuse(`BFCE_CMD_WRITE, 8'h00);
    wr(`BFCE_A_LEN, 32'h104);
    refuse(`BFCE_CMD_WRITE, 8'h00);
    wr(`BFCE_A_LEN, 32'h8);
    fill(8, 8'h10);
    run(`BFCE_CMD_WRITE, 8'h00);
    chk({dev.clen, 8'(dev.cnp)}, 32'h0708);
    for (int i = 0; i < 8; i++) chk(dev.pay[i], 32'h10 + i);
    rd(`BFCE_A_STAT);
    chk({30'h0, got[4:3]}, 32'h3);
    dev.bad = 1'b1;
    run(`BFCE_CMD_VERIFY, 8'h00);
    dev.bad = 1'b0;
    rd(`BFCE_A_STAT);
    chk({31'h0, got[2]}, 32'h1);
    wr(`BFCE_A_STAT, 32'h4);
  endtask
  task automatic t_read;
    dev.size = 32'h10;
    refuse(`BFCE_CMD_READ, 8'h00);
    run(`BFCE_CMD_SIZE, 8'h05);
    rd(`BFCE_A_SIZE);
    chk(got, 32'h10);
    wr(`BFCE_A_LEN, 32'h6);
    refuse(`BFCE_CMD_READ, 8'h00);
    wr(`BFCE_A_LEN, 32'h8);
    run(`BFCE_CMD_READ, 8'h00);
    run(`BFCE_CMD_READ, 8'h00);
    chk(dev.clen, 32'h7);
    rd(`BFCE_A_RCNT);
    chk(got, 32'h10);
    refuse(`BFCE_CMD_READ, 8'h00);
    wr(`BFCE_A_BPTR, 32'h0);
    rd(`BFCE_A_BDAT);
    chk({24'h0, got[7:0]}, 32'h43);
  endtask
  task automatic t_boot;
    wr(`BFCE_A_CFG, 32'h5);
    refuse(`BFCE_CMD_BATCH, 8'h00);
    refuse(`BFCE_CMD_READ, 8'h00);
    refuse(`BFCE_CMD_SELECT, 8'h01);
    run(`BFCE_CMD_ERASE, 8'h00);
    chk(dev.cop, 32'ha9);
    wr(`BFCE_A_LEN, 32'h4);
    fill(4, 8'h5a);
    run(`BFCE_CMD_WRITE, 8'h00);
    chk({dev.clen, 16'(dev.cnp)}, 32'hff0100);
    chk({dev.pay[3], dev.pay[4], dev.pay[255]}, 32'h5dffff);
    refuse(`BFCE_CMD_VERIFY, 8'h00);
    run(`BFCE_CMD_RATE, 8'h01);
    rd(`BFCE_A_STAT);
    chk({31'h0, got[5]}, 32'h1);
    run(`BFCE_CMD_VERIFY, 8'h00);
    chk(dev.cop, 32'ha4);
  endtask
  task automatic t_bin;
    int n;
    n = 0;
    wr(`BFCE_A_CFG, 32'h2);
    cmd(`BFCE_CMD_BIN, 8'h02);
    while (o_link_cs_n !== 1'b0 && n < 5000) begin
      @(posedge i_clock);
      #1 n++;
    end
    chk({31'h0, since >= 401 && since <= 1705}, 32'h1);
    wait_idle;
    chk({dev.cop, dev.carg}, 32'h3a02);
  endtask
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset;
    t_batch;
    t_prog;
    t_read;
    t_boot;
    t_bin;
    complete_run;
  end
  initial begin
    #900us;
    err_count++;
    complete_run;
  end
endmodule
